// [fan_start_ctrl.sv]
// Dynamic fan start temperature controller with APB register access.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module fan_start_ctrl #(
   parameter int CHANNELS = fan_start_pkg::NUM_CHAN
) (
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   input  wire logic                               clk_en,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [fan_start_pkg::ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]                        pwdata,
   output logic      [31:0]                        prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   input  wire logic                               monitor_tick,
   input  wire logic [23:0]                        zone_temp,
   output logic      [23:0]                        fan_start_temp,
   output logic      [23:0]                        duty,
   output logic      [2:0]                         low_alarm,
   output logic      [2:0]                         high_alarm
);
   import fan_start_pkg::*;

   // All state of the block in one packed struct.
   typedef struct packed {
      chan_cfg_type   [NUM_CHAN-1:0] cfg;
      chan_state_type [NUM_CHAN-1:0] ch;
      logic [7:0]                    cal1;
      logic [7:0]                    cal2;
      logic                          dyn_en;
      logic                          auto_en;
      logic                          crit_en;
      logic [31:0]                   rdata;
      logic                          ready;
      logic                          err;
   } state_type;

   state_type cur;  // Registered state.
   state_type next_cur; // Next value of the state.

   // Cycle code of a channel; remote 2 spans two registers.
   function automatic logic [2:0] cycle_code(input int idx,
                                             input logic [7:0] c1,
                                             input logic [7:0] c2);
      logic [2:0] code;
      code = 3'h0;
      case (idx)
         0: code = c2[CYC_R1_LSB +: CODE_WIDTH];
         1: code = c2[CYC_LO_LSB +: CODE_WIDTH];
         default: begin
            code = {c1[CYC_R2_MSB_BIT], c2[CYC_R2_LSB +: CODE_WIDTH-1]};
         end
      endcase
      return code;
   endfunction

   // Short cycle length in monitoring cycles for a code.
   function automatic logic [CNT_WIDTH-1:0] short_len(input logic [2:0] code);
      return CNT_WIDTH'(1) << (BASE_SHORT_SH + int'(code));
   endfunction

   // Duty from temperature, fan start and slope; full when critical.
   function automatic logic [7:0] calc_duty(input logic [7:0] t,
                                            input logic [7:0] start,
                                            input logic [3:0] rng,
                                            input logic [7:0] crit,
                                            input logic crit_on,
                                            input logic auto_on);
      logic [15:0] prod;
      prod = 16'h0000;
      if (crit_on && t > crit) begin
         return DUTY_FULL;
      end
      if (!auto_on || t < start) begin
         return DUTY_ZERO;
      end
      prod = 16'(t - start) * 16'(rng);
      return (prod > 16'(DUTY_FULL)) ? DUTY_FULL : prod[7:0];
   endfunction

   // Combinational update of the whole state.
   always_comb begin
      logic        wr_en;
      logic        rd_en;
      logic [2:0]  code;
      logic [CNT_WIDTH-1:0] slen;
      logic [7:0]  t;
      logic [7:0]  fs;
      logic        rising;
      wr_en = 1'b0;
      rd_en = 1'b0;
      code = 3'h0;
      slen = '0;
      t = 8'h00;
      fs = 8'h00;
      rising = 1'b0;
      next_cur = cur;
      next_cur.ready = 1'b0;
      next_cur.err = 1'b0;
      // Slave answers one cycle after the access phase begins.
      wr_en = psel && penable && !cur.ready && pwrite;
      rd_en = psel && penable && !cur.ready && !pwrite;
      if (psel && penable && !cur.ready) begin
         next_cur.ready = 1'b1;
      end
      next_cur.rdata = 32'h0000_0000;
      // Loop per channel.
      for (int i = 0; i < NUM_CHAN; i++) begin
         t = zone_temp[i*8 +: 8];
         fs = cur.ch[i].fan_start;
         code = cycle_code(i, cur.cal1, cur.cal2);
         slen = short_len(code);
         // Sticky limit flags; set beats a clear in the same cycle.
         if (t < cur.cfg[i].low_lim) begin
            next_cur.ch[i].low_flag = 1'b1;
         end
         if (t > cur.cfg[i].high_lim) begin
            next_cur.ch[i].high_flag = 1'b1;
         end
         next_cur.ch[i].phase = PH_IDLE;
         if (monitor_tick) begin
            next_cur.ch[i].prev_temp = t;
            rising = t > cur.ch[i].prev_temp;
            if (cur.ch[i].count >= (slen << 1) - CNT_WIDTH'(1)) begin
               next_cur.ch[i].count = '0;
               next_cur.ch[i].phase = PH_LONG;
            end else begin
               next_cur.ch[i].count = cur.ch[i].count + CNT_WIDTH'(1);
               if (cur.ch[i].count == slen - CNT_WIDTH'(1)) begin
                  next_cur.ch[i].phase = PH_SHORT;
               end
            end
            // Each zone tracks its own target independently.
            if (cur.dyn_en) begin
               case (next_cur.ch[i].phase)
                  PH_SHORT: begin
                     // Short cycle: rising above target, lower start.
                     if (t > cur.cfg[i].target && rising &&
                         fs > STEP_ONE) begin
                        fs = fs - STEP_ONE;
                     end
                  end
                  PH_LONG: begin
                     if (t > cur.cfg[i].target && fs > STEP_ONE) begin
                        fs = fs - STEP_ONE;
                     end else if (t < cur.cfg[i].low_lim &&
                                  fs < cur.cfg[i].high_lim) begin
                        fs = fs + STEP_ONE;
                     end
                  end
                  default: begin
                     fs = fs;
                  end
               endcase
            end else begin
               fs = cur.cfg[i].base_start;
            end
            next_cur.ch[i].fan_start = fs;
         end
         next_cur.ch[i].duty = calc_duty(t, next_cur.ch[i].fan_start,
                                         cur.cfg[i].range, cur.cfg[i].crit,
                                         cur.crit_en, cur.auto_en);
         // Register access for this channel's registers.
         if (paddr == ADDR_TARGET_R1 + 12'(i*4)) begin
            if (wr_en) next_cur.cfg[i].target = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cfg[i].target};
         end
         if (paddr == ADDR_LOW_LIM0 + 12'(i*8)) begin
            if (wr_en) next_cur.cfg[i].low_lim = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cfg[i].low_lim};
         end
         if (paddr == ADDR_LOW_LIM0 + 12'(i*8 + 4)) begin
            if (wr_en) next_cur.cfg[i].high_lim = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cfg[i].high_lim};
         end
         if (paddr == ADDR_FAN_BASE0 + 12'(i*4)) begin
            if (wr_en) next_cur.cfg[i].base_start = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cfg[i].base_start};
         end
         if (paddr == ADDR_RANGE0 + 12'(i*4)) begin
            if (wr_en) next_cur.cfg[i].range = pwdata[3:0];
            if (rd_en) next_cur.rdata = {28'h000_0000, cur.cfg[i].range};
         end
         if (paddr == ADDR_CRIT0 + 12'(i*4)) begin
            if (wr_en) next_cur.cfg[i].crit = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cfg[i].crit};
         end
         if (paddr == ADDR_FAN_START0 + 12'(i*4) && rd_en) begin
            next_cur.rdata = {24'h00_0000, cur.ch[i].fan_start};
         end
         if (paddr == ADDR_DUTY0 + 12'(i*4) && rd_en) begin
            next_cur.rdata = {24'h00_0000, cur.ch[i].duty};
         end
         // Write one to clear; a new event in the same cycle wins.
         if (wr_en && paddr == ADDR_STATUS) begin
            if (pwdata[i] && !(t < cur.cfg[i].low_lim)) begin
               next_cur.ch[i].low_flag = 1'b0;
            end
            if (pwdata[i+NUM_CHAN] && !(t > cur.cfg[i].high_lim)) begin
               next_cur.ch[i].high_flag = 1'b0;
            end
         end
      end
      // Shared registers.
      case (paddr)
         ADDR_CAL_CTRL1: begin
            if (wr_en) next_cur.cal1 = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cal1};
         end
         ADDR_CAL_CTRL2: begin
            if (wr_en) next_cur.cal2 = pwdata[7:0];
            if (rd_en) next_cur.rdata = {24'h00_0000, cur.cal2};
         end
         ADDR_FAN_CFG: begin
            if (wr_en) begin
               next_cur.auto_en = pwdata[0];
               next_cur.dyn_en = pwdata[1];
               next_cur.crit_en = pwdata[2];
            end
            if (rd_en) begin
               next_cur.rdata = {29'h0000_0000, cur.crit_en, cur.dyn_en,
                                 cur.auto_en};
            end
         end
         ADDR_STATUS: begin
            if (rd_en) begin
               for (int k = 0; k < NUM_CHAN; k++) begin
                  next_cur.rdata[k] = cur.ch[k].low_flag;
                  next_cur.rdata[k+NUM_CHAN] = cur.ch[k].high_flag;
               end
            end
         end
         default: begin
            next_cur.err = 1'b0;
         end
      endcase
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
         for (int i = 0; i < NUM_CHAN; i++) begin
            cur.cfg[i].target <= RST_TARGET;
            cur.cfg[i].low_lim <= RST_LOW_LIM;
            cur.cfg[i].high_lim <= RST_HIGH_LIM;
            cur.cfg[i].crit <= RST_CRIT;
            cur.cfg[i].range <= RST_RANGE;
            cur.cfg[i].base_start <= RST_FAN_START;
            cur.ch[i].fan_start <= RST_FAN_START;
         end
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state flip-flops.
   always_comb begin
      prdata = cur.rdata;
      pready = cur.ready;
      pslverr = cur.err;
      for (int i = 0; i < NUM_CHAN; i++) begin
         fan_start_temp[i*8 +: 8] = cur.ch[i].fan_start;
         duty[i*8 +: 8] = cur.ch[i].duty;
         low_alarm[i] = cur.ch[i].low_flag;
         high_alarm[i] = cur.ch[i].high_flag;
      end
   end

   // Checks of the loop and register behaviour.
   // A reading under the low limit sets the sticky flag at the next edge.
   chk_low_flag_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && zone_temp[7:0] < cur.cfg[0].low_lim
      |=> low_alarm[0])
      else $error("low flag not set");
   // A reading over the high limit sets the sticky flag at the next edge.
   chk_high_flag_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && zone_temp[15:8] > cur.cfg[1].high_lim
      |=> high_alarm[1])
      else $error("high flag not set");
   // With the critical override on, over the critical limit the duty is full.
   chk_crit_full_duty: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.crit_en && zone_temp[23:16] > cur.cfg[2].crit
      |=> duty[23:16] == DUTY_FULL)
      else $error("critical duty not full");
   // A start temperature at or over the high limit is never raised.
   chk_start_cap_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.dyn_en && cur.ch[1].fan_start >= cur.cfg[1].high_lim
      |=> fan_start_temp[15:8] <= $past(fan_start_temp[15:8]))
      else $error("fan start raised past cap");
   // Zone 0 is never raised while it is not under its low limit.
   chk_no_raise_hot: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.dyn_en && zone_temp[7:0] >= cur.cfg[0].low_lim
      |=> fan_start_temp[7:0] <= $past(fan_start_temp[7:0]))
      else $error("fan start raised while not cool");
   // A long cycle over the target lowers the start by exactly one degree.
   chk_long_lower: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.dyn_en && monitor_tick
      && next_cur.ch[0].phase == PH_LONG
      && zone_temp[7:0] > cur.cfg[0].target && cur.ch[0].fan_start > STEP_ONE
      |=> fan_start_temp[7:0] == $past(fan_start_temp[7:0]) - STEP_ONE)
      else $error("long cycle did not lower");
   // Between monitoring cycles the start temperatures never move.
   chk_no_change_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.dyn_en && !monitor_tick
      |=> $stable(fan_start_temp))
      else $error("fan start moved off cycle");
   // A write to the local target lands at the edge that raises pready.
   chk_target_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && psel && penable && pwrite && !pready
      && paddr == ADDR_TARGET_LO
      |=> pready ##0 cur.cfg[1].target == $past(pwdata[7:0]))
      else $error("target write lost");
   // Without the critical override a zone under its start runs no fan.
   chk_below_start_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && !cur.crit_en && zone_temp[15:8] < next_cur.ch[1].fan_start
      |=> duty[15:8] == DUTY_ZERO)
      else $error("fan on below start");
   // A long cycle under the low limit raises the start by one degree.
   chk_long_raise: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_en && cur.dyn_en && monitor_tick
      && next_cur.ch[1].phase == PH_LONG
      && zone_temp[15:8] < cur.cfg[1].low_lim
      && zone_temp[15:8] <= cur.cfg[1].target
      && cur.ch[1].fan_start < cur.cfg[1].high_lim
      |=> fan_start_temp[15:8] == $past(fan_start_temp[15:8]) + STEP_ONE)
      else $error("long cycle did not raise");
endmodule // fan_start_ctrl

// [fan_start_pkg.sv]
// Package with register map, field layout and constants of the fan start loop.
package fan_start_pkg;
   localparam int          NUM_CHAN       = 3;     // Remote 1, local, remote 2.
   localparam int          ADDR_WIDTH     = 12;    // APB byte address width.
   // Byte addresses of the registers.
   localparam logic [11:0] ADDR_TARGET_R1 = 12'h0_033 << 2;
   localparam logic [11:0] ADDR_TARGET_LO = 12'h0_034 << 2;
   localparam logic [11:0] ADDR_TARGET_R2 = 12'h0_035 << 2;
   localparam logic [11:0] ADDR_CAL_CTRL1 = 12'h0_036 << 2;
   localparam logic [11:0] ADDR_CAL_CTRL2 = 12'h0_037 << 2;
   localparam logic [11:0] ADDR_LOW_LIM0  = 12'h0_04E << 2;
   localparam logic [11:0] ADDR_FAN_CFG   = 12'h0_100;
   localparam logic [11:0] ADDR_STATUS    = 12'h0_104;
   localparam logic [11:0] ADDR_FAN_START0 = 12'h0_108;
   localparam logic [11:0] ADDR_DUTY0     = 12'h0_114;
   localparam logic [11:0] ADDR_FAN_BASE0 = 12'h0_120;
   localparam logic [11:0] ADDR_RANGE0    = 12'h0_12C;
   // Critical limits sit clear of the low and high limit words.
   localparam logic [11:0] ADDR_CRIT0     = 12'h0_06A << 2;
   // Reset values.
   localparam logic [7:0]  RST_TARGET     = 8'hA4;
   localparam logic [7:0]  RST_LOW_LIM    = 8'h01;
   localparam logic [7:0]  RST_HIGH_LIM   = 8'h7F;
   localparam logic [7:0]  RST_CRIT       = 8'hA4;
   localparam logic [7:0]  RST_FAN_START  = 8'h5A;
   localparam logic [3:0]  RST_RANGE      = 4'h4;
   // Field layout of the cycle code bits.
   localparam int          CYC_R1_LSB     = 0;
   localparam int          CYC_LO_LSB     = 3;
   localparam int          CYC_R2_LSB     = 6;
   localparam int          CYC_R2_MSB_BIT = 0;
   localparam int          CODE_WIDTH     = 3;
   localparam int          CODE_MAX_SHIFT = 7;
   localparam int          BASE_SHORT_SH  = 3;     // Code 000 gives 8 cycles.
   localparam int          CNT_WIDTH      = 12;    // Holds 2048.
   localparam logic [7:0]  STEP_ONE       = 8'h01;
   localparam logic [7:0]  DUTY_FULL      = 8'hFF; // 100 percent duty.
   localparam logic [7:0]  DUTY_ZERO      = 8'h00;
   // Loop phase of each channel.
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_SHORT = 2'b01,
      PH_LONG  = 2'b10
   } phase_type;
   // Per-channel configuration carried as one struct.
   typedef struct packed {
      logic [7:0] target;
      logic [7:0] low_lim;
      logic [7:0] high_lim;
      logic [7:0] crit;
      logic [3:0] range;
      logic [7:0] base_start;
   } chan_cfg_type;
   // Per-channel loop state.
   typedef struct packed {
      logic [CNT_WIDTH-1:0] count;
      logic [7:0]           fan_start;
      logic [7:0]           prev_temp;
      logic [7:0]           duty;
      logic                 low_flag;
      logic                 high_flag;
      phase_type            phase;
   } chan_state_type;
endpackage

// [zone_model.sv]
// Thermal zone and monitoring timebase model facing the fan start controller.
`timescale 1ns/1ps
module zone_model (
   input  wire logic        pclk,
   output logic             monitor_tick,
   output logic [23:0]      zone_temp
);
   // Zones start between the default low and high limits.
   initial begin
      monitor_tick = 1'b0;
      zone_temp    = 24'h30_3030;
   end
   // Moves one zone to a new temperature just after a clock edge.
   task automatic set_temp(input int ch, input logic [7:0] t);
      @(posedge pclk);
      zone_temp[ch*8 +: 8] <= t;
   endtask
   // Issues n monitoring cycles; each one-clock pulse is followed by three idle clocks.
   task automatic run_ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         monitor_tick <= 1'b1;
         @(posedge pclk);
         monitor_tick <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask
endmodule // zone_model

// [dynamic_fan_start_temp_control_bench.sv]
// Self-checking bench for the dynamic fan start temperature controller.
`timescale 1ns/1ps
module dynamic_fan_start_temp_control_bench;
   import fan_start_pkg::*;
   logic                  pclk, presetn, clk_en, psel, penable, pwrite;
   logic [ADDR_WIDTH-1:0] paddr;
   logic [31:0]           pwdata, prdata;
   logic                  pready, pslverr, monitor_tick;
   logic [23:0]           zone_temp, fan_start_temp, duty;
   logic [2:0]            low_alarm, high_alarm;
   int                    err_count, samples_checked;
   logic [31:0]           exp_q[$];   // Expected read data, oldest first.
   string                 name_q[$];  // What each expected value names.
   logic [7:0]            v, r, d;
   fan_start_ctrl u_fan_start_ctrl (.pclk, .presetn, .clk_en, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .monitor_tick, .zone_temp, .fan_start_temp, .duty, .low_alarm,
      .high_alarm);
   zone_model u_zone_model (.pclk, .monitor_tick, .zone_temp);
   // Free running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // One comparison; an unknown never counts as a match.
   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One APB transfer; an edge always passes first so no signal is set twice.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
         final_report();
      end else begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Notes the expected word, then reads it back.
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input string what);
      exp_q.push_back(e);
      name_q.push_back(what);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Compares the one fan start temperature of channel ch on the port.
   task automatic chk_start(input int ch, input logic [7:0] e);
      check("fan start port", {24'h00_0000, e}, {24'h00_0000,
            fan_start_temp[ch*8 +: 8]});
   endtask
   // Lets duty settle, then compares channel ch.
   task automatic chk_duty(input int ch, input logic [7:0] e);
      repeat (3) @(posedge pclk);
      check("duty", {24'h00_0000, e}, {24'h00_0000, duty[ch*8 +: 8]});
   endtask
   // Read data is taken at the edge that samples pready high.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         check("pslverr", 32'h0000_0000, {31'h0, pslverr});
         if (pwrite === 1'b0 && exp_q.size() > 0) begin
            check(name_q.pop_front(), exp_q.pop_front(), prdata);
         end
      end
   end
   // Main sequence.
   initial begin
      presetn = 1'b0;
      clk_en  = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      err_count       = 0;
      samples_checked = 0;
      void'($urandom(32'h0000_4720));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(ADDR_TARGET_R1 + 12'(4*i), {24'h0, RST_TARGET}, "target");
         rd(ADDR_FAN_START0 + 12'(4*i), {24'h0, RST_FAN_START}, "start");
         rd(ADDR_RANGE0 + 12'(4*i), {28'h0, RST_RANGE}, "range");
         rd(ADDR_LOW_LIM0 + 12'(8*i), {24'h0, RST_LOW_LIM},
            "low limit");
         rd(ADDR_LOW_LIM0 + 12'(8*i + 4), {24'h0, RST_HIGH_LIM},
            "high limit");
         rd(ADDR_CRIT0 + 12'(4*i), {24'h0, RST_CRIT}, "crit");
      end
      rd(ADDR_STATUS, 32'h0000_0000, "status");
      rd(12'hFFC, 32'h0000_0000, "unmapped");
      $display("test reset values done");
      // Random targets; upper bits of the word are dropped.
      for (int i = 0; i < 3; i++) begin
         v = 8'($urandom);
         apb(1'b1, ADDR_TARGET_R1 + 12'(4*i), {24'hFF_FFFF, v});
         rd(ADDR_TARGET_R1 + 12'(4*i), {24'h0, v}, "target rw");
         apb(1'b1, ADDR_TARGET_R1 + 12'(4*i), {24'h0, RST_TARGET});
      end
      apb(1'b1, ADDR_FAN_START0, 32'h0000_0011);
      rd(ADDR_FAN_START0, {24'h0, RST_FAN_START}, "read only start");
      $display("test target registers done");
      // Low and high crossings set sticky flags, cleared by writing ones.
      u_zone_model.set_temp(0, 8'h00);
      u_zone_model.set_temp(1, 8'h90);
      u_zone_model.run_ticks(2);
      check("low alarm", 32'h0000_0001, {29'h0, low_alarm});
      check("high alarm", 32'h0000_0002, {29'h0, high_alarm});
      u_zone_model.set_temp(0, 8'h30);
      u_zone_model.set_temp(1, 8'h30);
      u_zone_model.run_ticks(2);
      rd(ADDR_STATUS, 32'h0000_0011, "sticky status");
      apb(1'b1, ADDR_STATUS, 32'h0000_003F);
      rd(ADDR_STATUS, 32'h0000_0000, "cleared status");
      $display("test alarms done");
      // Automatic loop: duty slope set by range above the start point.
      apb(1'b1, ADDR_FAN_CFG, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         r = 8'(1 + $urandom % 15);
         d = 8'(1 + $urandom % 10);
         apb(1'b1, ADDR_RANGE0 + 12'(4*i), {24'h0, r});
         u_zone_model.set_temp(i, RST_FAN_START + d);
         u_zone_model.run_ticks(1);
         chk_duty(i, 8'(d * r));
         u_zone_model.set_temp(i, 8'h50);
         chk_duty(i, DUTY_ZERO);
      end
      $display("test automatic duty done");
      // Critical limit, once enabled, forces full duty whatever the loop settings.
      apb(1'b1, ADDR_RANGE0 + 12'h008, 32'h0000_0001);
      u_zone_model.set_temp(2, 8'hB0);
      u_zone_model.run_ticks(1);
      chk_duty(2, 8'h56);
      apb(1'b1, ADDR_FAN_CFG, 32'h0000_0005);
      chk_duty(2, DUTY_FULL);
      apb(1'b1, ADDR_FAN_CFG, 32'h0000_0004);
      chk_duty(2, DUTY_FULL);
      rd(ADDR_DUTY0 + 12'h008, {24'h0, DUTY_FULL}, "duty reg");
      $display("test critical limit done");
      // Base loop first, then dynamic mode; zones settle below targets.
      u_zone_model.set_temp(0, 8'h50);
      u_zone_model.set_temp(1, 8'h30);
      u_zone_model.set_temp(2, 8'h60);
      apb(1'b1, ADDR_CAL_CTRL2, 32'h0000_0040);
      apb(1'b1, ADDR_CAL_CTRL1, 32'h0000_0000);
      apb(1'b1, ADDR_FAN_CFG, 32'h0000_0003);
      u_zone_model.run_ticks(32);
      for (int i = 0; i < 3; i++) begin
         chk_start(i, RST_FAN_START);
      end
      // Zone 0 and 2 run hot, zone 1 drops under its low limit.
      apb(1'b1, ADDR_TARGET_R1, 32'h0000_0040);
      apb(1'b1, ADDR_TARGET_R2, 32'h0000_0050);
      u_zone_model.set_temp(1, 8'h00);
      u_zone_model.run_ticks(32);
      chk_start(0, RST_FAN_START - 8'h02);
      chk_start(1, RST_FAN_START + 8'h02);
      chk_start(2, RST_FAN_START - 8'h01);
      rd(ADDR_FAN_START0, {24'h0, RST_FAN_START - 8'h02}, "start0");
      // Remote 2 code takes its top bit from the other register: 101.
      apb(1'b1, ADDR_CAL_CTRL1, 32'h0000_0001);
      u_zone_model.run_ticks(640);
      rd(ADDR_FAN_START0 + 12'h004, {24'h0, RST_HIGH_LIM}, "start cap");
      chk_start(0, RST_FAN_START - 8'h2A);
      chk_start(2, RST_FAN_START - 8'h02);
      $display("test dynamic start done");
      // Clock enable low freezes the loop although ticks keep coming.
      @(posedge pclk);
      clk_en <= 1'b0;
      u_zone_model.run_ticks(32);
      chk_start(0, RST_FAN_START - 8'h2A);
      @(posedge pclk);
      clk_en <= 1'b1;
      $display("test clock enable done");
      // A reset in mid-run brings the registers back to their defaults.
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_TARGET_R1, {24'h0, RST_TARGET}, "target reset");
      chk_start(0, RST_FAN_START);
      $display("test mid-run reset done");
      final_report();
   end
endmodule // dynamic_fan_start_temp_control_bench
